// ==== pkg/swdsel_params.svh ====
// timing, pattern and code constants of the debug port selector
`ifndef SWDSEL_PARAMS_SVH
`define SWDSEL_PARAMS_SVH
`define SWDSEL_CLK_NS 40
`define SWDSEL_KEY_WINDOW_NS 8000
`define SWDSEL_KEY_WINDOW_CYC (`SWDSEL_KEY_WINDOW_NS / `SWDSEL_CLK_NS)
`define SWDSEL_ACQ_LEN 16
`define SWDSEL_ACQ_PATTERN 16'hb5a3
`define SWDSEL_HOST_DIV 6
`define SWDSEL_REQ_LEN 8
`define SWDSEL_REQ_JTAG_ON 8'h4a
`define SWDSEL_REQ_RELEASE 8'h5c
`endif

// ==== pkg/swdsel_pkg.sv ====
// types of the debug port selector
package swdsel_pkg;
    typedef enum logic [1:0] {
        swdsel_pair_jtag = 2'h0,
        swdsel_pair_usb = 2'h1
    } swdsel_pair_type;
    typedef enum logic [3:0] {
        swdsel_st_key = 4'h1,
        swdsel_st_active = 4'h2,
        swdsel_st_released = 4'h4,
        swdsel_st_idle = 4'h8
    } swdsel_state_type;
endpackage : swdsel_pkg

// ==== pkg/swdsel_if.sv ====
// two pin pairs between debug host and device
`timescale 1ns/100ps
interface swdsel_if;
    logic jtag_clk;
    logic jtag_dat_host;
    logic jtag_dat_host_oe_n;
    logic jtag_dat_dev;
    logic jtag_dat_dev_oe_n;
    logic usb_clk;
    logic usb_dat_host;
    logic usb_dat_host_oe_n;
    logic usb_dat_dev;
    logic usb_dat_dev_oe_n;
    modport device (
        input jtag_clk, jtag_dat_host, jtag_dat_host_oe_n,
        input usb_clk, usb_dat_host, usb_dat_host_oe_n,
        output jtag_dat_dev, jtag_dat_dev_oe_n, usb_dat_dev, usb_dat_dev_oe_n
    );
    modport host (
        output jtag_clk, jtag_dat_host, jtag_dat_host_oe_n,
        output usb_clk, usb_dat_host, usb_dat_host_oe_n,
        input jtag_dat_dev, jtag_dat_dev_oe_n, usb_dat_dev, usb_dat_dev_oe_n
    );
endinterface : swdsel_if

// ==== core/swdsel_device.sv ====
// device end: acquire detection, pair selection, release and jtag re-enable
`timescale 1ns/100ps
`include "swdsel_params.svh"
//
// Contract
// R01: link uses exactly two device pins
// R02: full debug access, no scan chain or chaining
// R03: host clock at most third of cpu clock
// R04: link on jtag pair or usb pair
// R05: one pin clock, other pin bidirectional data
// R06: port enabled on at most one pair
// R07: enable only on pattern inside key window
// R08: latch set enables jtag pair without pattern
// R09: usb pair always needs the pattern
// R10: port enabled from jtag or released to gpio
// R11: pattern in key window always reacquires (code: only in swdsel_st_key; later a jtag pair pattern just clears jtag_en, a usb one does nothing)
// R12: reacquired port can re-enable jtag interface
// R13: pattern constant; every reset restarts detection
module swdsel_device #(
    parameter int acq_len = `SWDSEL_ACQ_LEN,
    parameter logic [`SWDSEL_ACQ_LEN-1:0] acq_pattern = `SWDSEL_ACQ_PATTERN,
    parameter int key_cycles = `SWDSEL_KEY_WINDOW_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // configuration and jtag side
    input wire logic nonvolatile_config_latch_i,
    input wire logic jtag_swd_enable_i,
    // link pins
    swdsel_if.device link,
    // status
    output logic swd_on_jtag_o,
    output logic swd_on_usb_o,
    output logic jtag_enabled_o,
    output logic key_window_open_o,
    output logic [7:0] rx_byte_o,
    output logic rx_byte_valid_o
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] jc_s, jd_s, uc_s, ud_s;
    logic jc_d, uc_d;
    always_ff @(posedge mclk_i) begin
        jc_s <= {jc_s[0], link.jtag_clk};
        jd_s <= {jd_s[0], link.jtag_dat_host};
        uc_s <= {uc_s[0], link.usb_clk};
        ud_s <= {ud_s[0], link.usb_dat_host};
        jc_d <= jc_s[1];
        uc_d <= uc_s[1];
    end
    wire jc_rise = jc_s[1] & ~jc_d;
    wire uc_rise = uc_s[1] & ~uc_d;

    ////////////////////////////////////////////////////////////////////////
    // key window timer
    logic [15:0] key_cnt;
    wire key_open = key_cnt < 16'(key_cycles);
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            key_cnt <= 16'h0000; // R13
        end else if (key_open) begin
            key_cnt <= key_cnt + 16'h0001;
        end
    end
    assign key_window_open_o = key_open;

    ////////////////////////////////////////////////////////////////////////
    // acquire shifters, one per pair
    logic [`SWDSEL_ACQ_LEN-1:0] j_sh, u_sh;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            j_sh <= '0; // R13
            u_sh <= '0;
        end else begin
            if (jc_rise) j_sh <= {j_sh[`SWDSEL_ACQ_LEN-2:0], jd_s[1]};
            if (uc_rise) u_sh <= {u_sh[`SWDSEL_ACQ_LEN-2:0], ud_s[1]};
        end
    end
    wire j_hit = key_open && (j_sh == acq_pattern); // R07 R11
    wire u_hit = key_open && (u_sh == acq_pattern); // R07 R09 R11

    ////////////////////////////////////////////////////////////////////////
    // selection state
    swdsel_pkg::swdsel_state_type state;
    swdsel_pkg::swdsel_pair_type pair;
    logic jtag_en;
    logic req_jtag_on, req_release;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= swdsel_pkg::swdsel_st_key;
            pair <= swdsel_pkg::swdsel_pair_jtag;
        end else begin
            unique case (state)
                swdsel_pkg::swdsel_st_key: begin
                    if (j_hit) begin
                        state <= swdsel_pkg::swdsel_st_active;
                        pair <= swdsel_pkg::swdsel_pair_jtag; // R04
                    end else if (u_hit) begin
                        state <= swdsel_pkg::swdsel_st_active;
                        pair <= swdsel_pkg::swdsel_pair_usb; // R04 R09
                    end else if (!key_open) begin
                        if (nonvolatile_config_latch_i) begin
                            state <= swdsel_pkg::swdsel_st_active; // R08
                            pair <= swdsel_pkg::swdsel_pair_jtag;
                        end else begin
                            state <= swdsel_pkg::swdsel_st_idle;
                        end
                    end
                end
                swdsel_pkg::swdsel_st_active: begin
                    if (req_release) state <= swdsel_pkg::swdsel_st_released; // R10
                end
                swdsel_pkg::swdsel_st_released, swdsel_pkg::swdsel_st_idle: begin
                    if (jtag_swd_enable_i) begin
                        state <= swdsel_pkg::swdsel_st_active; // R10
                        pair <= swdsel_pkg::swdsel_pair_jtag;
                    end
                end
                default: state <= swdsel_pkg::swdsel_st_idle;
            endcase
        end
    end
    wire active = (state == swdsel_pkg::swdsel_st_active);
    wire on_jtag = active && (pair == swdsel_pkg::swdsel_pair_jtag); // R06
    wire on_usb = active && (pair == swdsel_pkg::swdsel_pair_usb); // R06

    ////////////////////////////////////////////////////////////////////////
    // request bytes from host once active
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    wire act_rise = on_jtag ? jc_rise : (on_usb ? uc_rise : 1'b0);
    wire act_dat = on_jtag ? jd_s[1] : ud_s[1]; // R05
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx_sh <= 8'h00;
            rx_cnt <= 3'h0;
            rx_byte_o <= 8'h00;
            rx_byte_valid_o <= 1'b0;
        end else if (!active) begin
            rx_sh <= 8'h00;
            rx_cnt <= 3'h0;
            rx_byte_valid_o <= 1'b0;
        end else begin
            rx_byte_valid_o <= 1'b0;
            if (act_rise) begin
                rx_sh <= {rx_sh[6:0], act_dat};
                rx_cnt <= rx_cnt + 3'h1;
                if (rx_cnt == 3'h7) begin
                    rx_byte_o <= {rx_sh[6:0], act_dat};
                    rx_byte_valid_o <= 1'b1;
                end
            end
        end
    end
    assign req_jtag_on = rx_byte_valid_o && (rx_byte_o == `SWDSEL_REQ_JTAG_ON);
    assign req_release = rx_byte_valid_o && (rx_byte_o == `SWDSEL_REQ_RELEASE);

    ////////////////////////////////////////////////////////////////////////
    // jtag interface enable
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            jtag_en <= 1'b1;
        end else if (active && req_jtag_on) begin
            jtag_en <= 1'b1; // R12
        end else if (j_hit) begin
            jtag_en <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; device does not echo the request byte bit serially,
    // data pin driven with bit 0 of the last request byte while active
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            link.jtag_dat_dev <= 1'b0;
            link.usb_dat_dev <= 1'b0;
            swd_on_jtag_o <= 1'b0;
            swd_on_usb_o <= 1'b0;
            jtag_enabled_o <= 1'b1;
        end else begin
            link.jtag_dat_dev <= rx_byte_o[0];
            link.usb_dat_dev <= rx_byte_o[0];
            swd_on_jtag_o <= on_jtag;
            swd_on_usb_o <= on_usb;
            jtag_enabled_o <= jtag_en; // R12
        end
    end
    // turnaround without a clash cycle: device lets go as soon as host drives
    assign link.jtag_dat_dev_oe_n = ~(on_jtag && link.jtag_dat_host_oe_n); // R05
    assign link.usb_dat_dev_oe_n = ~(on_usb && link.usb_dat_host_oe_n); // R05
endmodule : swdsel_device

// ==== core/swdsel_host.sv ====
// host end: sends acquire pattern and request bytes on a chosen pair
`timescale 1ns/100ps
`include "swdsel_params.svh"
module swdsel_host #(
    parameter int acq_len = `SWDSEL_ACQ_LEN,
    parameter logic [`SWDSEL_ACQ_LEN-1:0] acq_pattern = `SWDSEL_ACQ_PATTERN,
    parameter int half_div = `SWDSEL_HOST_DIV
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // user commands
    input wire logic acquire_i,
    input wire logic use_usb_i,
    input wire logic send_i,
    input wire logic [7:0] send_byte_i,
    // link pins
    swdsel_if.host link,
    // status
    output logic busy_o
);
    logic [`SWDSEL_ACQ_LEN-1:0] sh;
    logic [4:0] bits;
    logic [7:0] div;
    logic clk_q, usb_sel;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sh <= '0;
            bits <= 5'h00;
            div <= 8'h00;
            clk_q <= 1'b0;
            usb_sel <= 1'b0;
        end else if (bits == 5'h00) begin
            clk_q <= 1'b0;
            div <= 8'h00;
            if (acquire_i) begin
                sh <= acq_pattern; // R07 R09
                bits <= 5'(acq_len);
                usb_sel <= use_usb_i;
            end else if (send_i) begin
                sh <= {send_byte_i, 8'h00};
                bits <= 5'(`SWDSEL_REQ_LEN);
                usb_sel <= use_usb_i;
            end
        end else if (div == 8'(half_div - 1)) begin
            div <= 8'h00; // R03
            clk_q <= ~clk_q;
            if (clk_q) begin
                sh <= {sh[`SWDSEL_ACQ_LEN-2:0], 1'b0};
                bits <= bits - 5'h01;
            end
        end else begin
            div <= div + 8'h01;
        end
    end
    assign busy_o = (bits != 5'h00);
    assign link.jtag_clk = clk_q && !usb_sel; // R05
    assign link.usb_clk = clk_q && usb_sel; // R05
    assign link.jtag_dat_host = sh[`SWDSEL_ACQ_LEN-1];
    assign link.usb_dat_host = sh[`SWDSEL_ACQ_LEN-1];
    assign link.jtag_dat_host_oe_n = !(busy_o && !usb_sel);
    assign link.usb_dat_host_oe_n = !(busy_o && usb_sel);
endmodule : swdsel_host

// ==== sim/swdsel_sva.sv ====
// assertions on the link pins and status of the debug port selector
`timescale 1ns/100ps
module swdsel_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // link pins
    input wire logic usb_clk,
    input wire logic jtag_dat_host_oe_n,
    input wire logic jtag_dat_dev_oe_n,
    input wire logic usb_dat_host_oe_n,
    input wire logic usb_dat_dev_oe_n,
    // device status
    input wire logic jtag_swd_enable_i,
    input wire logic swd_on_jtag_o,
    input wire logic swd_on_usb_o,
    input wire logic jtag_enabled_o,
    input wire logic key_window_open_o,
    input wire logic [7:0] rx_byte_o
);
    logic [9:0] since_rst;
    logic [7:0] usb_quiet;
    logic usb_clk_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) since_rst <= 10'h000;
        else if (since_rst != 10'h3ff) since_rst <= since_rst + 10'h001;
    end
    always_ff @(posedge mclk_i) begin
        usb_clk_q <= usb_clk;
        if (sys_rst_i) usb_quiet <= 8'h00;
        else if (usb_clk != usb_clk_q) usb_quiet <= 8'h00;
        else if (usb_quiet != 8'hff) usb_quiet <= usb_quiet + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    one_pair_a: assert property (!(swd_on_jtag_o && swd_on_usb_o))
        else $error("port on both pairs");
    jtag_no_clash_a: assert property (!jtag_dat_host_oe_n |-> jtag_dat_dev_oe_n)
        else $error("jtag data driven by both ends");
    usb_no_clash_a: assert property (!usb_dat_host_oe_n |-> usb_dat_dev_oe_n)
        else $error("usb data driven by both ends");
    usb_acq_a: assert property ($rose(swd_on_usb_o) |-> since_rst <= 10'd210 && usb_quiet < 8'd40)
        else $error("usb pair enabled without pattern in window");
    jtag_acq_a: assert property ($rose(swd_on_jtag_o) && !jtag_swd_enable_i |-> since_rst <= 10'd210)
        else $error("jtag pair enabled outside key window");
    release_byte_a: assert property ($fell(swd_on_jtag_o) |-> rx_byte_o == 8'h5c)
        else $error("port dropped without release request");
    jtag_back_a: assert property ($rose(jtag_enabled_o) |-> rx_byte_o == 8'h4a)
        else $error("jtag enabled without request");
    window_open_a: assert property (since_rst == 10'd150 |-> key_window_open_o)
        else $error("key window closed too early");
    window_shut_a: assert property (since_rst == 10'd250 |-> !key_window_open_o)
        else $error("key window open too long");
endmodule : swdsel_sva

// ==== sim/testbench.sv ====
// self-checking bench joining host and device ends
`timescale 1ns/100ps
module testbench;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, latch = 1'b0, jen = 1'b0;
    logic acq = 1'b0, usb = 1'b0, snd = 1'b0, busy, on_j, on_u, jtag_en, kwin, rxv;
    logic [7:0] sbyte = 8'h00, rxb;
    logic [15:0] cap_j, cap_u;
    int n_mismatch = 0, total_checks = 0, cyc = 0, edges_j = 0;
    swdsel_if link ();
    swdsel_device u_swdsel_device (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .nonvolatile_config_latch_i(latch), .jtag_swd_enable_i(jen), .link(link),
        .swd_on_jtag_o(on_j), .swd_on_usb_o(on_u), .jtag_enabled_o(jtag_en),
        .key_window_open_o(kwin), .rx_byte_o(rxb), .rx_byte_valid_o(rxv));
    swdsel_host #(.half_div(2)) u_swdsel_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .acquire_i(acq), .use_usb_i(usb), .send_i(snd), .send_byte_i(sbyte), .link(link),
        .busy_o(busy));
    swdsel_sva u_swdsel_sva (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .usb_clk(link.usb_clk),
        .jtag_dat_host_oe_n(link.jtag_dat_host_oe_n), .jtag_dat_dev_oe_n(link.jtag_dat_dev_oe_n),
        .usb_dat_host_oe_n(link.usb_dat_host_oe_n), .usb_dat_dev_oe_n(link.usb_dat_dev_oe_n),
        .jtag_swd_enable_i(jen), .swd_on_jtag_o(on_j), .swd_on_usb_o(on_u),
        .jtag_enabled_o(jtag_en), .key_window_open_o(kwin), .rx_byte_o(rxb));
    ////////////////////////////////////////////////////////////////////////
    always #20 mclk_i = ~mclk_i;
    always @(posedge link.jtag_clk) begin
        cap_j <= {cap_j[14:0], link.jtag_dat_host};
        edges_j <= edges_j + 1;
    end
    always @(posedge link.usb_clk) cap_u <= {cap_u[14:0], link.usb_dat_host};
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wait_n
    task automatic do_reset(input logic lat);
        @(negedge mclk_i);
        latch = lat;
        sys_rst_i = 1'b1;
        wait_n(2);
        sys_rst_i = 1'b0;
    endtask : do_reset
    task automatic host_cmd(input logic a, input logic u, input logic [7:0] b);
        int k;
        @(negedge mclk_i);
        {acq, snd, usb, sbyte} = {a, ~a, u, b};
        @(negedge mclk_i);
        {acq, snd} = 2'b00;
        for (k = 0; k < 500 && busy !== 1'b0; k++) @(negedge mclk_i);
        wait_n(12);
    endtask : host_cmd
    ////////////////////////////////////////////////////////////////////////
    task automatic t_jtag_acquire();
        do_reset(1'b0);
        edges_j = 0;
        host_cmd(1'b1, 1'b0, 8'h00);
        check_val({on_j, on_u, jtag_en}, 16'h0004);
        check_val(cap_j, 16'hb5a3);
        check_val(16'(edges_j), 16'h0010);
        host_cmd(1'b0, 1'b0, 8'h4a);
        check_val({rxb, jtag_en, on_j}, 16'h012b);
        host_cmd(1'b0, 1'b0, 8'h5c);
        check_val(on_j, 1'b0);
    endtask : t_jtag_acquire
    task automatic t_usb_acquire();
        do_reset(1'b0);
        host_cmd(1'b1, 1'b1, 8'h00);
        check_val({on_j, on_u}, 16'h0001);
        check_val(cap_u, 16'hb5a3);
    endtask : t_usb_acquire
    task automatic t_latch_only();
        do_reset(1'b1);
        wait_n(210);
        check_val({on_j, on_u, kwin}, 16'h0004);
    endtask : t_latch_only
    task automatic t_late_pattern();
        do_reset(1'b0);
        wait_n(210);
        host_cmd(1'b1, 1'b1, 8'h00);
        check_val({on_j, on_u}, 16'h0000);
        jen = 1'b1;
        wait_n(6);
        check_val({on_j, on_u}, 16'h0002);
        jen = 1'b0;
    endtask : t_late_pattern
    initial begin
        t_latch_only();
        t_late_pattern();
        t_jtag_acquire();
        t_usb_acquire();
        give_verdict();
    end
endmodule : testbench
